/* File: hw/vmpd_defs.vh */
// constants for the vid / sleep-mode / phase decoder
`ifndef VMPD_DEFS_VH
`define VMPD_DEFS_VH
`define VMPD_CLK_MHZ 100
`define VMPD_PG_WAIT_US 10
`define VMPD_PG_WAIT_CYC (`VMPD_PG_WAIT_US * `VMPD_CLK_MHZ)
`define VMPD_RAMP_MIN_MS 3
`define VMPD_RAMP_MAX_MS 12
`define VMPD_RAMP_CYC (`VMPD_RAMP_MIN_MS * 1000 * `VMPD_CLK_MHZ)
`define VMPD_MASK_US 100
`define VMPD_MASK_CYC (`VMPD_MASK_US * `VMPD_CLK_MHZ)
`define VMPD_SLEW_CYC 9'h100
`define VMPD_FSW_MIN_KHZ 250
`define VMPD_FSW_MAX_KHZ 1000
`define VMPD_PER_MAX (`VMPD_CLK_MHZ * 1000 / `VMPD_FSW_MIN_KHZ)
`define VMPD_PER_MIN (`VMPD_CLK_MHZ * 1000 / `VMPD_FSW_MAX_KHZ)
`define VMPD_DAC_TOP_MV 11'h6ac
`define VMPD_DAC_STEP_MV 11'h010
`define VMPD_ADR_CTRL 8'h00
`define VMPD_ADR_PERIOD 8'h04
`define VMPD_ADR_DUTY 8'h08
`define VMPD_ADR_BOOT 8'h0c
`define VMPD_ADR_DEEP 8'h10
`define VMPD_ADR_DEEPER 8'h14
`define VMPD_ADR_STATUS 8'h18
`define VMPD_ADR_CMD 8'h1c
`define VMPD_ADR_VID 8'h20
`define VMPD_RST_PERIOD 9'h0c8
`define VMPD_RST_DUTY 9'h000
`define VMPD_RST_BOOT 11'h4b0
`define VMPD_RST_DEEP 11'h3e8
`define VMPD_RST_DEEPER 11'h2ee
`define VMPD_MODE_ACTIVE 2'h0
`define VMPD_MODE_DEEP 2'h1
`define VMPD_MODE_DEEPER 2'h2
`endif

/* File: hw/vmpd_sync.v */
// two-flop synchroniser for pin inputs
module vmpd_sync #(
  parameter W = 1
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);
  reg [W-1:0] meta_r;
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= {W{1'b0}};
      q_o <= {W{1'b0}};
    end else if (ce_i) begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule // vmpd_sync

/* File: hw/vmpd_top.v */
// vid decode, sleep-mode select, two-phase pwm timing and power-good control
//
// The Wishbone register port and the placing of the registers are this design's own decisions.
`include "vmpd_defs.vh"
// What this block and its system do
// (R1) two phases switch half a period apart
// (R2) select high two phases, low one phase
// (R3) system drives select from sleep signals
// (R4) code decodes to 1708 mV minus 16 mV/step
// (R5) system drives all code inputs always
// (R6) power-good masked during setpoint transitions
// (R7) active mode tracks code changes after start-up
// (R8) sleep inputs pick active, deep or deeper setpoint
// (R9) deep sleep lowers setpoint, enables diode emulation
// (R10) switching period held within 250 kHz..1 MHz
// (R11) boot setpoint, then code reached within 3..12 ms
// (R12) wait 10 us after power-good before ramp
// (R13) inputs registered before decoding
module vmpd_top #(
  parameter RAMP_CYC = `VMPD_RAMP_CYC,
  parameter MASK_CYC = `VMPD_MASK_CYC
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [5:0] voltage_id_code_i,
  input wire deep_sleep_enable_n_i,
  input wire deeper_sleep_enable_i,
  input wire phase_count_select_i,
  input wire power_good_i,
  input wire out_of_regulation_i,
  output reg power_good_o,
  output reg power_good_oe_n_o,
  output reg pwm1_o,
  output reg pwm2_o,
  output reg diode_emulation_o,
  output reg two_phase_o,
  output reg [1:0] mode_o,
  output reg [10:0] command_mv_o
);
  localparam ST_OFF = 5'h01;
  localparam ST_BOOT = 5'h02;
  localparam ST_WAIT = 5'h04;
  localparam ST_RAMP = 5'h08;
  localparam ST_RUN = 5'h10;
  localparam [31:0] PER_MAX_W = `VMPD_PER_MAX;
  localparam [31:0] PER_MIN_W = `VMPD_PER_MIN;
  localparam [31:0] PG_WAIT_LAST = `VMPD_PG_WAIT_CYC - 1;
  localparam [31:0] RAMP_LAST = RAMP_CYC - 1;
  localparam [31:0] MASK_LOAD = MASK_CYC;

  wire [10:0] pins_s;
  wire [5:0] vid_s;
  wire deep_sleep_enable_n_n_s, deeper_sleep_enable_s, pcs_s, pg_in_s, oor_s;
  vmpd_sync #(.W(11)) u_sync ( // (R13)
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i({voltage_id_code_i, deep_sleep_enable_n_i, deeper_sleep_enable_i, phase_count_select_i,
      power_good_i, out_of_regulation_i}),
    .q_o(pins_s)
  );
  assign vid_s = pins_s[10:5];
  assign deep_sleep_enable_n_n_s = pins_s[4];
  assign deeper_sleep_enable_s = pins_s[3];
  assign pcs_s = pins_s[2];
  assign pg_in_s = pins_s[1];
  assign oor_s = pins_s[0];

  reg run_en_r;
  reg [8:0] period_r, duty_r;
  reg [10:0] boot_r, deep_r, deeper_r;
  reg [5:0] vid_r;
  reg [4:0] state_r;
  reg [18:0] tmr_r;
  reg [8:0] slew_r;
  reg [13:0] mask_r;
  reg [8:0] cnt_r;
  reg [10:0] target_prev_r;

  // code to millivolts
  wire [10:0] vid_mv = `VMPD_DAC_TOP_MV - (`VMPD_DAC_STEP_MV * {5'h00, vid_r}); // (R4)
  reg [1:0] mode_nxt;
  reg [10:0] target_nxt;
  always @* begin
    case ({deep_sleep_enable_n_n_s, deeper_sleep_enable_s}) // (R8)
      2'b10: begin
        mode_nxt = `VMPD_MODE_ACTIVE;
        target_nxt = vid_mv; // (R7)
      end
      2'b00: begin
        mode_nxt = `VMPD_MODE_DEEP;
        target_nxt = deep_r; // (R9)
      end
      default: begin
        mode_nxt = `VMPD_MODE_DEEPER;
        target_nxt = deeper_r;
      end
    endcase
  end

  // period clamp on write
  wire [8:0] per_w = wb_dat_i[8:0] > PER_MAX_W[8:0] ? PER_MAX_W[8:0] : wb_dat_i[8:0];
  wire [8:0] per_c = per_w < PER_MIN_W[8:0] ? PER_MIN_W[8:0] : per_w; // (R10)
  wire [8:0] half_w = {1'b0, period_r[8:1]};
  wire [8:0] cnt2_w = (cnt_r >= half_w) ? cnt_r - half_w : cnt_r + (period_r - half_w);
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_req & wb_we_i & wb_sel_i[0];
  wire switching = ~state_r[0];

  // register bus
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      run_en_r <= 1'b0;
      period_r <= `VMPD_RST_PERIOD;
      duty_r <= `VMPD_RST_DUTY;
      boot_r <= `VMPD_RST_BOOT;
      deep_r <= `VMPD_RST_DEEP;
      deeper_r <= `VMPD_RST_DEEPER;
    end else if (ce_i) begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      if (wb_req & ~wb_we_i) begin
        case (wb_adr_i)
          `VMPD_ADR_CTRL: wb_dat_o <= {31'h0, run_en_r};
          `VMPD_ADR_PERIOD: wb_dat_o <= {23'h0, period_r};
          `VMPD_ADR_DUTY: wb_dat_o <= {23'h0, duty_r};
          `VMPD_ADR_BOOT: wb_dat_o <= {21'h0, boot_r};
          `VMPD_ADR_DEEP: wb_dat_o <= {21'h0, deep_r};
          `VMPD_ADR_DEEPER: wb_dat_o <= {21'h0, deeper_r};
          `VMPD_ADR_STATUS: wb_dat_o <= {21'h0, ~power_good_oe_n_o, state_r, mask_r != 14'h0,
            diode_emulation_o, mode_o, two_phase_o};
          `VMPD_ADR_CMD: wb_dat_o <= {21'h0, command_mv_o};
          `VMPD_ADR_VID: wb_dat_o <= {26'h0, vid_r};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
      if (wb_wr) begin
        case (wb_adr_i)
          `VMPD_ADR_CTRL: run_en_r <= wb_dat_i[0];
          `VMPD_ADR_PERIOD: period_r <= per_c; // (R10)
          `VMPD_ADR_DUTY: duty_r <= wb_dat_i[8:0];
          `VMPD_ADR_BOOT: boot_r <= {wb_sel_i[1] ? wb_dat_i[10:8] : boot_r[10:8], wb_dat_i[7:0]};
          `VMPD_ADR_DEEP: deep_r <= {wb_sel_i[1] ? wb_dat_i[10:8] : deep_r[10:8], wb_dat_i[7:0]};
          `VMPD_ADR_DEEPER: deeper_r <= {wb_sel_i[1] ? wb_dat_i[10:8] : deeper_r[10:8], wb_dat_i[7:0]};
          default: ;
        endcase
      end
    end
  end

  // start-up sequencer and setpoint slew
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_OFF;
      tmr_r <= 19'h00000;
      slew_r <= 9'h000;
      vid_r <= 6'h00;
      mode_o <= `VMPD_MODE_ACTIVE;
      command_mv_o <= 11'h000;
      target_prev_r <= 11'h000;
      mask_r <= 14'h0000;
    end else if (ce_i) begin
      target_prev_r <= target_nxt;
      case (state_r)
        ST_OFF: begin
          command_mv_o <= 11'h000;
          if (run_en_r) begin
            state_r <= ST_BOOT;
          end
        end
        ST_BOOT: begin
          command_mv_o <= boot_r; // (R11)
          tmr_r <= 19'h00000;
          slew_r <= 9'h000;
          if (pg_in_s) begin
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          tmr_r <= tmr_r + 19'h00001;
          if (tmr_r == PG_WAIT_LAST[18:0]) begin // (R12)
            vid_r <= vid_s; // (R11)
            tmr_r <= 19'h00000;
            state_r <= ST_RAMP;
          end
        end
        ST_RAMP: begin
          tmr_r <= tmr_r + 19'h00001;
          slew_r <= (slew_r == `VMPD_SLEW_CYC - 9'h001) ? 9'h000 : slew_r + 9'h001;
          if (tmr_r == RAMP_LAST[18:0]) begin // (R11)
            command_mv_o <= vid_mv;
            mode_o <= mode_nxt;
            state_r <= ST_RUN;
          end else if (slew_r == 9'h000 && command_mv_o != vid_mv) begin
            command_mv_o <= (command_mv_o < vid_mv) ? command_mv_o + 11'h001 : command_mv_o - 11'h001;
          end
        end
        ST_RUN: begin
          vid_r <= vid_s; // (R7)
          mode_o <= mode_nxt; // (R8)
          command_mv_o <= target_nxt;
          if (target_nxt != target_prev_r || mode_nxt != mode_o) begin
            mask_r <= MASK_LOAD[13:0]; // (R6)
          end else if (mask_r != 14'h0000) begin
            mask_r <= mask_r - 14'h0001;
          end
        end
        default: state_r <= ST_OFF;
      endcase
      if (~run_en_r) begin
        state_r <= ST_OFF;
        mask_r <= 14'h0000;
      end
    end
  end

  // phase timing and pin outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 9'h000;
      pwm1_o <= 1'b0;
      pwm2_o <= 1'b0;
      two_phase_o <= 1'b0;
      diode_emulation_o <= 1'b0;
      power_good_o <= 1'b0;
      power_good_oe_n_o <= 1'b1;
    end else if (ce_i) begin
      cnt_r <= (cnt_r >= period_r - 9'h001) ? 9'h000 : cnt_r + 9'h001;
      two_phase_o <= pcs_s; // (R2)
      pwm1_o <= switching & (cnt_r < duty_r);
      pwm2_o <= switching & pcs_s & (cnt2_w < duty_r); // (R1)
      diode_emulation_o <= state_r[4] & (mode_nxt == `VMPD_MODE_DEEP); // (R9)
      power_good_o <= 1'b0;
      power_good_oe_n_o <= ~(state_r[0] | (state_r[4] & oor_s & (mask_r == 14'h0000))); // (R6)
    end
  end
endmodule // vmpd_top

/* File: verif/vmpd_pm_model.sv */
// platform power-management model driving code, sleep and select pins
module vmpd_pm_model (
  input wire logic clk_i,
  input wire logic [5:0] code_i,
  input wire logic [1:0] sleep_i,
  input wire logic sel_deeper_i,
  input wire logic pg_hold_i,
  input wire logic dev_oe_n_i,
  output logic [5:0] code_o = 6'h00,
  output logic deep_n_o = 1'b1,
  output logic deeper_o = 1'b0,
  output logic sel_o = 1'b1,
  output wire logic pg_line_o
);
  always @(posedge clk_i) begin
    code_o <= code_i;
    {deep_n_o, deeper_o} <= sleep_i;
    sel_o <= sel_deeper_i ? !sleep_i[0] : sleep_i[1];
  end
  // pulled-up shared line, low if either side pulls
  assign pg_line_o = pg_hold_i & dev_oe_n_i;
endmodule // vmpd_pm_model

/* File: verif/vmpd_top_properties.sv */
// assertions on the decoder top-level ports
module vmpd_top_properties #(
  parameter RAMP_CYC = 2000,
  parameter MASK_CYC = 50
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire deep_sleep_enable_n_i,
  input wire deeper_sleep_enable_i,
  input wire phase_count_select_i,
  input wire power_good_i,
  input wire power_good_oe_n_o,
  input wire pwm1_o,
  input wire pwm2_o,
  input wire diode_emulation_o,
  input wire two_phase_o,
  input wire [1:0] mode_o,
  input wire [10:0] command_mv_o
);
  logic [1:0] rel_r;
  always_ff @(posedge clk_i) rel_r <= rst_i ? 2'h0 : rel_r + {1'b0, rel_r != 2'h3};
  // cycles since the phase-count output last moved
  logic tp_q_r;
  logic [7:0] tp_age_r;
  always_ff @(posedge clk_i) tp_q_r <= two_phase_o;
  always_ff @(posedge clk_i) tp_age_r <= (rst_i || two_phase_o != tp_q_r) ? 8'h00 :
    tp_age_r + {7'h00, tp_age_r != 8'hff};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_taken: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  // bench runs a 200-cycle period, so channel 2 trails by 100
  a_phase_shift: assert property ($fell(pwm1_o) && two_phase_o |-> ##100
    ($fell(pwm2_o) || tp_age_r < 8'h64)) else $error("phase 2 not half period late");
  a_single_phase: assert property (!two_phase_o && !$past(two_phase_o) |-> !pwm2_o) else $error("pwm2 in one-phase");
  a_select_follow: assert property (rel_r == 2'h3 |-> two_phase_o == $past(phase_count_select_i, 3))
    else $error("two_phase wrong");
  a_mode_decode: assert property (rel_r == 2'h3 |-> mode_o == ($past(deeper_sleep_enable_i, 3) ? 2'h2 :
    {1'b0, !$past(deep_sleep_enable_n_i, 3)})) else $error("mode wrong");
  a_diode_deep: assert property (diode_emulation_o |-> mode_o == 2'h1) else $error("diode outside deep");
  a_mask_hold: assert property ($changed(command_mv_o) |-> ##1 power_good_oe_n_o[*8])
    else $error("power-good not masked");
  a_period_min: assert property ($rose(pwm1_o) |=> (!$rose(pwm1_o))[*8]) else $error("period short");
  a_pg_wait: assert property ($rose(power_good_i) |-> ##1 $stable(command_mv_o)[*8]) else $error("ramp early");
  cover property (diode_emulation_o);
  cover property ($rose(pwm2_o));
  cover property (mode_o == 2'h2);
endmodule // vmpd_top_properties
bind vmpd_top vmpd_top_properties #(.RAMP_CYC(RAMP_CYC), .MASK_CYC(MASK_CYC)) u_vmpd_top_properties (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .deep_sleep_enable_n_i, .deeper_sleep_enable_i,
  .phase_count_select_i, .power_good_i, .power_good_oe_n_o, .pwm1_o, .pwm2_o, .diode_emulation_o,
  .two_phase_o, .mode_o, .command_mv_o);

/* File: verif/vmpd_tb_top.sv */
// self-checking bench for the decoder
module vmpd_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, oor = 1'b0, pg_hold = 1'b0, sel_deeper = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, wb_dat_o;
  logic [5:0] code = 6'h00, voltage_id_code_i;
  logic [1:0] sleep = 2'h2, mode_o;
  logic [10:0] command_mv_o;
  logic wb_ack_o, power_good_o, power_good_oe_n_o, pwm1_o, pwm2_o, diode_emulation_o, two_phase_o;
  logic deep_sleep_enable_n_i, deeper_sleep_enable_i, phase_count_select_i, power_good_i;
  int failures = 0, check_count = 0, n, h1, h2;
  int rv [6] = '{0, 'hc8, 0, 'h4b0, 'h3e8, 'h2ee};
  int em [4] = '{1, 2, 0, 2};
  int ec [4] = '{1000, 750, 700, 750};
  always #5 clk_i = ~clk_i;
  vmpd_top #(.RAMP_CYC(2000), .MASK_CYC(50)) u_vmpd_top (.clk_i, .rst_i, .ce_i(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o, .wb_ack_o,
    .voltage_id_code_i, .deep_sleep_enable_n_i, .deeper_sleep_enable_i, .phase_count_select_i, .power_good_i,
    .out_of_regulation_i(oor), .power_good_o, .power_good_oe_n_o, .pwm1_o, .pwm2_o, .diode_emulation_o,
    .two_phase_o, .mode_o, .command_mv_o);
  vmpd_pm_model u_vmpd_pm_model (.clk_i, .code_i(code), .sleep_i(sleep), .sel_deeper_i(sel_deeper),
    .pg_hold_i(pg_hold), .dev_oe_n_i(power_good_oe_n_o), .code_o(voltage_id_code_i),
    .deep_n_o(deep_sleep_enable_n_i), .deeper_o(deeper_sleep_enable_i), .sel_o(phase_count_select_i),
    .pg_line_o(power_good_i));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    if (failures == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin @(posedge clk_i); k++; end while (wb_ack_o !== 1'b1 && k < 50);
    if (k == 50) begin failures++; stop_test(); end
    rdat = wb_dat_o;
    cyc <= 1'b0;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) begin bus(1'b0, 8'h04 * i, 0); check(rdat, rv[i]); end
    bus(1'b0, 8'h04, 0); check(rdat, 32'h0c8);
    bus(1'b1, 8'h04, 32'h1f4); bus(1'b0, 8'h04, 0); check(rdat, 32'h190);
    bus(1'b1, 8'h04, 32'h10); bus(1'b0, 8'h04, 0); check(rdat, 32'h64);
    bus(1'b1, 8'h04, 32'hc8); bus(1'b1, 8'h08, 32'h28); bus(1'b1, 8'h00, 32'h1);
    repeat (10) @(posedge clk_i);
    check(32'(command_mv_o), 32'h4b0);
    pg_hold <= 1'b1;
    repeat (900) @(posedge clk_i);
    bus(1'b0, 8'h18, 0); check(32'(rdat[9:5]), 32'h4);
    check(32'(command_mv_o), 32'h4b0);
    repeat (150) @(posedge clk_i);
    bus(1'b0, 8'h18, 0); check(32'(rdat[9:5]), 32'h8);
    n = 0;
    do begin bus(1'b0, 8'h18, 0); n++; end while (rdat[9:5] !== 5'h10 && n < 1000);
    if (n == 1000) begin failures++; stop_test(); end
    check(32'(command_mv_o), 32'h6ac);
    for (int c = 0; c < 64; c++) begin
      code <= 6'(c);
      repeat (6) @(posedge clk_i);
      check(32'(command_mv_o), 32'(1708 - 16 * c));
    end
    n = 0;
    h1 = 1;
    while (!(h1 == 0 && pwm1_o === 1'b1) && n < 400) begin
      h1 = int'(pwm1_o === 1'b1);
      @(posedge clk_i);
      n++;
    end
    if (n == 400) begin failures++; stop_test(); end
    repeat (99) @(posedge clk_i);
    check(32'(pwm2_o), 32'h0);
    @(posedge clk_i);
    check(32'(pwm2_o), 32'h1);
    h1 = 0;
    h2 = 0;
    repeat (200) begin
      @(posedge clk_i);
      h1 += int'(pwm1_o);
      h2 += int'(pwm2_o);
    end
    check(h1, 40);
    check(h2, 40);
    check(32'(power_good_o), 32'h0);
    for (int s = 0; s < 2; s++) begin
      sel_deeper <= s[0];
      for (int m = 0; m < 4; m++) begin
        sleep <= 2'(m);
        repeat (8) @(posedge clk_i);
        check(32'(mode_o), em[m]);
        check(32'(command_mv_o), ec[m]);
        check(32'(diode_emulation_o), 32'(m == 0));
        check(32'(two_phase_o), s ? 32'(!m[0]) : 32'(m[1]));
      end
    end
    h1 = 0;
    h2 = 0;
    repeat (200) begin
      @(posedge clk_i);
      h1 += int'(pwm1_o);
      h2 += int'(pwm2_o);
    end
    check(h1, 40);
    check(h2, 0);
    sleep <= 2'h2;
    oor <= 1'b1;
    repeat (80) @(posedge clk_i);
    check(32'(power_good_oe_n_o), 32'h0);
    code <= 6'h05;
    repeat (8) @(posedge clk_i);
    check(32'(power_good_oe_n_o), 32'h1);
    repeat (60) @(posedge clk_i);
    check(32'(power_good_oe_n_o), 32'h0);
    oor <= 1'b0;
    repeat (10) @(posedge clk_i);
    check(32'(power_good_oe_n_o), 32'h1);
    stop_test();
  end
endmodule // vmpd_tb_top
